// [src/rep_ctl_pkg.sv]
// constants and types for the string repeat prefix control
// assumes a core clock domain with synchronous active-low reset
package rep_ctl_pkg;
   localparam logic [7:0] PFX_EQ_OR_ALL = 8'hF3;
   localparam logic [7:0] PFX_UNEQUAL   = 8'hF2;
   localparam logic [7:0] OP_INS_B      = 8'h6C;
   localparam logic [7:0] OP_INS_W      = 8'h6D;
   localparam logic [7:0] OP_PORT_OUTPUT_STRING_OP_B     = 8'h6E;
   localparam logic [7:0] OP_PORT_OUTPUT_STRING_OP_W     = 8'h6F;
   localparam logic [7:0] OP_MOVE_B     = 8'hA4;
   localparam logic [7:0] OP_MOVE_W     = 8'hA5;
   localparam logic [7:0] OP_CMP_B      = 8'hA6;
   localparam logic [7:0] OP_CMP_W      = 8'hA7;
   localparam logic [7:0] OP_STORE_B    = 8'hAA;
   localparam logic [7:0] OP_STORE_W    = 8'hAB;
   localparam logic [7:0] OP_LOAD_B     = 8'hAC;
   localparam logic [7:0] OP_LOAD_W     = 8'hAD;
   localparam logic [7:0] OP_SCAN_B     = 8'hAE;
   localparam logic [7:0] OP_SCAN_W     = 8'hAF;
   localparam logic [31:0] CNT_RESET    = 32'h0000_0000;

   typedef enum logic [1:0] {
      PFX_NONE        = 2'h0,
      ITERATE_PREFIX  = 2'h1,
      ITERATE_EQUAL   = 2'h2,
      ITERATE_UNEQUAL = 2'h3
   } pfx_t;

   typedef enum logic [1:0] {
      ELEM_BYTE  = 2'h0,
      ELEM_WORD  = 2'h1,
      ELEM_DWORD = 2'h2
   } elem_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CHECK = 3'b001,
      ST_PASS  = 3'b011,
      ST_WAIT  = 3'b010,
      ST_TEST  = 3'b110,
      ST_DONE  = 3'b111
   } state_t;
endpackage

// [src/rep_decode_if.sv]
// decoded prefix/opcode bundle between decoder and loop control
// assumes decoder and controller share the core clock
`timescale 1ns/1ps
`default_nettype none
interface rep_decode_if;
   rep_ctl_pkg::pfx_t  pfx;
   rep_ctl_pkg::elem_t elem;
   logic               is_string;
   logic               is_compare;
   logic               legal;
   modport decoder (output pfx, elem, is_string, is_compare, legal);
   modport control (input pfx, elem, is_string, is_compare, legal);
endinterface
`default_nettype wire

// [src/rep_prefix_decode.sv]
// combinational decode of repeat prefix and string opcode
// assumes prefix and opcode bytes stable while start is sampled
`timescale 1ns/1ps
`default_nettype none
module rep_prefix_decode (
   // instruction bytes
   input  wire logic [7:0] prefix_byte,
   input  wire logic [7:0] opcode_byte,
   input  wire logic       operand_32,
   // decoded result
   rep_decode_if.decoder   dec
);
   always_comb begin
      dec.is_string  = 1'b1;
      dec.is_compare = 1'b0;
      dec.elem       = operand_32 ? rep_ctl_pkg::ELEM_DWORD
                                  : rep_ctl_pkg::ELEM_WORD;
      unique case (opcode_byte)
         rep_ctl_pkg::OP_INS_B, rep_ctl_pkg::OP_PORT_OUTPUT_STRING_OP_B,
         rep_ctl_pkg::OP_MOVE_B, rep_ctl_pkg::OP_LOAD_B,
         rep_ctl_pkg::OP_STORE_B: begin
            dec.elem = rep_ctl_pkg::ELEM_BYTE;
         end
         rep_ctl_pkg::OP_INS_W, rep_ctl_pkg::OP_PORT_OUTPUT_STRING_OP_W,
         rep_ctl_pkg::OP_MOVE_W, rep_ctl_pkg::OP_LOAD_W,
         rep_ctl_pkg::OP_STORE_W: begin
         end
         rep_ctl_pkg::OP_CMP_B, rep_ctl_pkg::OP_SCAN_B: begin
            dec.elem       = rep_ctl_pkg::ELEM_BYTE;
            dec.is_compare = 1'b1;
         end
         rep_ctl_pkg::OP_CMP_W, rep_ctl_pkg::OP_SCAN_W: begin
            dec.is_compare = 1'b1;
         end
         default: begin
            dec.is_string = 1'b0;
         end
      endcase
      // F3 serves two aliases (plain or equal), F2 only unequal
      if (prefix_byte == rep_ctl_pkg::PFX_EQ_OR_ALL) begin
         dec.pfx = dec.is_compare ? rep_ctl_pkg::ITERATE_EQUAL
                                  : rep_ctl_pkg::ITERATE_PREFIX;
      end else if (prefix_byte == rep_ctl_pkg::PFX_UNEQUAL) begin
         dec.pfx = rep_ctl_pkg::ITERATE_UNEQUAL;
      end else begin
         dec.pfx = rep_ctl_pkg::PFX_NONE;
      end
      // unconditional on moves/io/load/store, conditional on cmp/scan
      dec.legal = dec.is_string && (dec.pfx != rep_ctl_pkg::PFX_NONE) &&
                  (dec.is_compare ||
                   dec.pfx == rep_ctl_pkg::ITERATE_PREFIX);
   end
endmodule
`default_nettype wire

// [src/string_repeat_prefix_control.sv]
// iteration control for one repeated string instruction
// assumes the string unit reports each pass with pass_done and
// pass_fault, and the core services interrupts on int_take
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - F3 repeats or repeats-equal, F2 repeats-unequal
// - loop ends when count decremented to zero
// - plain prefix on io/move/load/store, conditional cmp/scan
// - zero/nonzero aliases behave as equal/unequal
// - equal stops on zero_flag 0, unequal on 1
// - zero_flag before loop is never consulted
// - suspension keeps indices, pointer, count of last pass
// - unequal cmp/scan page fault restores flags
// - count_reg16 for 16-bit, count_reg32 for 32-bit addresses
// - interrupts, execute, decrement, zero exit, flag test
// - prefix alters no status flag itself
// - loop logic raises no exception itself
// - prefix covers only its one string instruction
// - prefix on non-string instruction is undefined
// - A4 moves bytes, A5 words or doublewords
module string_repeat_prefix_control #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // instruction from decode
   input  wire logic             start,
   input  wire logic [7:0]       prefix_byte,
   input  wire logic [7:0]       opcode_byte,
   input  wire logic             addr_32,
   input  wire logic             operand_32,
   input  wire logic [CNT_W-1:0] count_in,
   input  wire logic [31:0]      flags_in,
   input  wire logic [31:0]      ip_in,
   input  wire logic [31:0]      src_idx_in,
   input  wire logic [31:0]      dst_idx_in,
   // interrupt hand-shake with core
   input  wire logic             int_pending,
   output logic                  int_take,
   // string execution unit
   output logic                  pass_req,
   output rep_ctl_pkg::elem_t    pass_elem,
   input  wire logic             pass_done,
   input  wire logic             pass_fault,
   input  wire logic             pass_page_fault,
   input  wire logic             zero_flag,
   input  wire logic [31:0]      src_idx_next,
   input  wire logic [31:0]      dst_idx_next,
   // architectural results
   output logic                  busy,
   output logic                  done,
   output logic                  suspended,
   output logic                  flags_restore,
   output logic [31:0]           flags_out,
   output logic [31:0]           instruction_pointer,
   output logic [31:0]           source_index,
   output logic [31:0]           dest_index,
   output logic [CNT_W-1:0]      count_out
);
   rep_decode_if dec ();

   rep_prefix_decode u_dec (
      .prefix_byte (prefix_byte),
      .opcode_byte (opcode_byte),
      .operand_32  (operand_32),
      .dec         (dec)
   );

   rep_ctl_pkg::state_t state_ff, nxt_state;
   rep_ctl_pkg::pfx_t   pfx_ff, nxt_pfx;
   rep_ctl_pkg::elem_t  elem_ff, nxt_elem;
   logic                a32_ff, nxt_a32;
   logic                cmp_ff, nxt_cmp;
   logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
   logic [31:0]         flags_ff, nxt_flags;
   logic [31:0]         ip_ff, nxt_ip;
   logic [31:0]         si_ff, nxt_si;
   logic [31:0]         di_ff, nxt_di;
   logic                done_ff, nxt_done;
   logic                susp_ff, nxt_susp;
   logic                rest_ff, nxt_rest;
   logic                pf_ff, nxt_pf;
   logic                zf_stop;

   // active counter view by address size
   function automatic logic [CNT_W-1:0] count_view(
      input logic [CNT_W-1:0] c, input logic a32);
      logic [CNT_W-1:0] v;
      v = c;
      if (!a32) begin
         v = {{(CNT_W-16){1'b0}}, c[15:0]};
      end
      return v;
   endfunction

   // decrement only the selected width, upper half untouched
   function automatic logic [CNT_W-1:0] count_dec(
      input logic [CNT_W-1:0] c, input logic a32);
      logic [CNT_W-1:0] v;
      logic [15:0]      lo;
      v  = c - {{(CNT_W-1){1'b0}}, 1'b1};
      lo = c[15:0] - 16'h0001;
      if (!a32) begin
         v = {c[CNT_W-1:16], lo};
      end
      return v;
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_pfx   = pfx_ff;
      nxt_elem  = elem_ff;
      nxt_a32   = a32_ff;
      nxt_cmp   = cmp_ff;
      nxt_cnt   = cnt_ff;
      nxt_flags = flags_ff;
      nxt_ip    = ip_ff;
      nxt_si    = si_ff;
      nxt_di    = di_ff;
      nxt_done  = 1'b0;
      nxt_susp  = susp_ff;
      nxt_rest  = 1'b0;
      nxt_pf    = pf_ff;
      unique case (state_ff)
         rep_ctl_pkg::ST_IDLE: begin
            if (start) begin
               // undefined pairings run as plain loops over the full count
               nxt_pfx   = dec.legal ? dec.pfx
                                     : rep_ctl_pkg::ITERATE_PREFIX;
               nxt_cmp   = dec.is_compare && dec.legal;
               nxt_elem  = dec.elem;
               nxt_a32   = addr_32;
               nxt_cnt   = count_in;
               nxt_flags = flags_in;
               nxt_ip    = ip_in;
               nxt_si    = src_idx_in;
               nxt_di    = dst_idx_in;
               nxt_susp  = 1'b0;
               nxt_pf    = 1'b0;
               nxt_state = rep_ctl_pkg::ST_CHECK;
            end
         end
         rep_ctl_pkg::ST_CHECK: begin
            if (count_view(cnt_ff, a32_ff) == '0) begin
               nxt_state = rep_ctl_pkg::ST_DONE;
            end else if (int_pending) begin
               // suspend between passes, state resumable
               nxt_susp  = 1'b1;
               nxt_state = rep_ctl_pkg::ST_DONE;
            end else begin
               nxt_state = rep_ctl_pkg::ST_PASS;
            end
         end
         rep_ctl_pkg::ST_PASS: begin
            nxt_state = rep_ctl_pkg::ST_WAIT;
         end
         rep_ctl_pkg::ST_WAIT: begin
            if (pass_fault) begin
               // fault from the wrapped op only; count kept
               nxt_susp  = 1'b1;
               nxt_pf    = pass_page_fault && cmp_ff &&
                           pfx_ff == rep_ctl_pkg::ITERATE_UNEQUAL;
               nxt_state = rep_ctl_pkg::ST_DONE;
            end else if (pass_done) begin
               nxt_si    = src_idx_next;
               nxt_di    = dst_idx_next;
               nxt_cnt   = count_dec(cnt_ff, a32_ff);
               nxt_state = rep_ctl_pkg::ST_TEST;
            end
         end
         rep_ctl_pkg::ST_TEST: begin
            // zero_flag here comes from this pass only
            if (count_view(cnt_ff, a32_ff) == '0) begin
               nxt_state = rep_ctl_pkg::ST_DONE;
            end else if (zf_stop) begin
               nxt_state = rep_ctl_pkg::ST_DONE;
            end else begin
               nxt_state = rep_ctl_pkg::ST_CHECK;
            end
         end
         rep_ctl_pkg::ST_DONE: begin
            nxt_done  = 1'b1;
            // restore pulse lines up with done
            nxt_rest  = pf_ff;
            nxt_pf    = 1'b0;
            nxt_state = rep_ctl_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = rep_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= rep_ctl_pkg::ST_IDLE;
         pfx_ff   <= rep_ctl_pkg::PFX_NONE;
         elem_ff  <= rep_ctl_pkg::ELEM_BYTE;
         a32_ff   <= 1'b0;
         cmp_ff   <= 1'b0;
         cnt_ff   <= rep_ctl_pkg::CNT_RESET[CNT_W-1:0];
         flags_ff <= 32'h0000_0000;
         ip_ff    <= 32'h0000_0000;
         si_ff    <= 32'h0000_0000;
         di_ff    <= 32'h0000_0000;
         done_ff  <= 1'b0;
         susp_ff  <= 1'b0;
         rest_ff  <= 1'b0;
         pf_ff    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pfx_ff   <= nxt_pfx;
         elem_ff  <= nxt_elem;
         a32_ff   <= nxt_a32;
         cmp_ff   <= nxt_cmp;
         cnt_ff   <= nxt_cnt;
         flags_ff <= nxt_flags;
         ip_ff    <= nxt_ip;
         si_ff    <= nxt_si;
         di_ff    <= nxt_di;
         done_ff  <= nxt_done;
         susp_ff  <= nxt_susp;
         rest_ff  <= nxt_rest;
         pf_ff    <= nxt_pf;
      end
   end

   assign int_take            = state_ff == rep_ctl_pkg::ST_CHECK &&
                                count_view(cnt_ff, a32_ff) != '0 &&
                                int_pending;
   assign pass_req            = state_ff == rep_ctl_pkg::ST_PASS;
   assign pass_elem           = elem_ff;
   assign busy                = state_ff != rep_ctl_pkg::ST_IDLE;
   assign done                = done_ff;
   assign suspended           = susp_ff;
   assign flags_restore       = rest_ff;
   assign flags_out           = flags_ff;
   assign instruction_pointer = ip_ff;
   assign source_index        = si_ff;
   assign dest_index          = di_ff;
   assign count_out           = cnt_ff;

   // conditional exit uses zero_flag of this pass only
   assign zf_stop = (pfx_ff == rep_ctl_pkg::ITERATE_EQUAL && !zero_flag) ||
                    (pfx_ff == rep_ctl_pkg::ITERATE_UNEQUAL && zero_flag);
endmodule
`default_nettype wire

// [testbench/string_repeat_prefix_control_chk.sv]
// assertions on the repeat prefix loop control ports
// bound onto the control top; single core clock domain
`timescale 1ns/1ps
`default_nettype none
module string_repeat_prefix_control_chk #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic             ref_clk,
   input wire logic             rst_n,
   // instruction in
   input wire logic             start,
   input wire logic             addr_32,
   input wire logic [CNT_W-1:0] count_in,
   input wire logic [31:0]      flags_in,
   input wire logic             int_pending,
   // loop side
   input wire logic             int_take,
   input wire logic             pass_req,
   input wire logic             pass_done,
   input wire logic             busy,
   input wire logic             done,
   input wire logic             suspended,
   input wire logic             flags_restore,
   input wire logic [31:0]      flags_out,
   input wire logic [CNT_W-1:0] count_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic go;
   logic zc;
   assign go = start && !busy;
   assign zc = addr_32 ? (count_in == '0) : (count_in[15:0] == 16'h0000);
   a_zero_no_pass: assert property (
      go && zc |=> !pass_req [*2] ##1 done)
      else $error("zero count ran a pass");
   a_take_busy: assert property (go |=> busy)
      else $error("start not taken");
   a_done_once: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_pass_once: assert property (pass_req |=> !pass_req)
      else $error("pass request longer than one cycle");
   a_int_cause: assert property (
      int_take |-> int_pending && busy && !pass_req)
      else $error("interrupt taken without cause");
   a_int_suspend: assert property (
      int_take |-> ##2 (done && suspended))
      else $error("interrupt did not suspend");
   a_flags_capture: assert property (
      go |=> flags_out == $past(flags_in))
      else $error("flags changed by prefix");
   a_restore_done: assert property (
      flags_restore |-> done && suspended)
      else $error("flags restore outside fault end");
   a_count_cause: assert property (
      $changed(count_out) |-> $past(pass_done) || $past(start))
      else $error("count moved without a pass");
   c_zero: cover property (go && zc);
   c_int: cover property (int_take);
   c_restore: cover property (flags_restore);
endmodule
`default_nettype wire

// [testbench/string_repeat_prefix_control_bench.sv]
// self-checking bench for the repeat prefix loop control
// bench plays decode, core interrupt logic and string unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) cmp_count++; \
   if ((g) !== (e)) begin failures++; \
   $display("FAIL %s exp %0h got %0h", n, e, g); end
module string_repeat_prefix_control_bench;
   logic               ref_clk, rst_n, start, addr_32, operand_32;
   logic               int_pending, pass_done, pass_fault;
   logic               pass_page_fault, zero_flag;
   logic [7:0]         prefix_byte, opcode_byte, zf_seq;
   logic [31:0]        count_in, flags_in, ip_in, src_idx_in, dst_idx_in;
   logic [31:0]        src_idx_next, dst_idx_next, count_out;
   logic               int_take, pass_req, busy, done, suspended;
   logic               flags_restore;
   logic [31:0]        flags_out, instruction_pointer;
   logic [31:0]        source_index, dest_index;
   rep_ctl_pkg::elem_t pass_elem, exp_elem;
   int                 failures, cmp_count, npass, lat, fault_at, int_at;
   string_repeat_prefix_control #(.CNT_W(32)) u_string_repeat_prefix_control (
      .ref_clk, .rst_n, .start, .prefix_byte, .opcode_byte, .addr_32,
      .operand_32, .count_in, .flags_in, .ip_in, .src_idx_in, .dst_idx_in,
      .int_pending, .int_take, .pass_req, .pass_elem, .pass_done,
      .pass_fault, .pass_page_fault, .zero_flag, .src_idx_next,
      .dst_idx_next, .busy, .done, .suspended, .flags_restore, .flags_out,
      .instruction_pointer, .source_index, .dest_index, .count_out);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // string unit: answers each pass after lat cycles
   initial forever begin
      @(posedge ref_clk);
      if (pass_req === 1'b1) begin
         `CHK("elem", exp_elem, pass_elem)
         repeat (lat) @(posedge ref_clk);
         #2;
         pass_fault = (npass == fault_at);
         pass_page_fault = pass_fault;
         pass_done = !pass_fault;
         zero_flag = zf_seq[npass];
         if (!pass_fault) src_idx_next = src_idx_next + 32'h4;
         dst_idx_next = ~src_idx_next;
         npass++;
         if (npass == int_at) int_pending = 1'b1;
         @(posedge ref_clk);
         #2;
         pass_done = 1'b0;
         pass_fault = 1'b0;
      end
   end
   task automatic issue(input logic [7:0] p, op, input logic a32, o32,
                        input logic [31:0] cnt);
      int i;
      prefix_byte = p;
      opcode_byte = op;
      addr_32 = a32;
      operand_32 = o32;
      count_in = cnt;
      flags_in = flags_in + 32'h11;
      ip_in = ip_in + 32'h10;
      src_idx_in = ip_in ^ 32'h5000;
      dst_idx_in = ~src_idx_in;
      src_idx_next = src_idx_in;
      exp_elem = !op[0] ? rep_ctl_pkg::ELEM_BYTE :
                 (o32 ? rep_ctl_pkg::ELEM_DWORD : rep_ctl_pkg::ELEM_WORD);
      npass = 0;
      start = 1'b1;
      @(posedge ref_clk);
      #2;
      start = 1'b0;
      for (i = 0; i < 300 && done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #2;
      end
      `CHK("done", 1'b1, done)
      `CHK("ip", ip_in, instruction_pointer)
      `CHK("src", src_idx_next, source_index)
      `CHK("dst", ~src_idx_next, dest_index)
   endtask
   task automatic t_zero_entry;
      issue(8'hF3, 8'hA4, 1'b1, 1'b0, 32'h0);
      `CHK("npass", 0, npass)
      `CHK("count", 32'h0, count_out)
      `CHK("susp", 1'b0, suspended)
      `CHK("busy", 1'b0, busy)
   endtask
   task automatic t_plain_ops;
      logic [7:0] ops [6] = '{8'h6C, 8'h6E, 8'hA5, 8'hAA, 8'hAD, 8'h6F};
      for (int k = 0; k < 6; k++) begin
         zf_seq = 8'h00;
         issue(8'hF3, ops[k], 1'b1, k[0], 32'h2);
         `CHK("npass", 2, npass)
         `CHK("count", 32'h0, count_out)
      end
   endtask
   task automatic t_equal;
      zero_flag = 1'b0;
      zf_seq = 8'h03;
      lat = 3;
      issue(8'hF3, 8'hA6, 1'b1, 1'b1, 32'h5);
      lat = 0;
      `CHK("npass", 3, npass)
      `CHK("count", 32'h2, count_out)
   endtask
   task automatic t_unequal;
      zero_flag = 1'b1;
      zf_seq = 8'h04;
      issue(8'hF2, 8'hAF, 1'b1, 1'b0, 32'h5);
      `CHK("npass", 3, npass)
      `CHK("count", 32'h2, count_out)
   endtask
   task automatic t_count16;
      zf_seq = 8'h00;
      issue(8'hF3, 8'hAB, 1'b0, 1'b1, 32'h0001_0002);
      `CHK("npass", 2, npass)
      `CHK("count", 32'h0001_0000, count_out)
      issue(8'hF3, 8'hAB, 1'b0, 1'b1, 32'h0003_0000);
      `CHK("npass", 0, npass)
   endtask
   task automatic t_interrupt;
      int_at = 2;
      issue(8'hF3, 8'hA4, 1'b1, 1'b0, 32'h4);
      `CHK("susp", 1'b1, suspended)
      `CHK("count", 32'h2, count_out)
      `CHK("npass", 2, npass)
      `CHK("restore", 1'b0, flags_restore)
      int_pending = 1'b0;
      int_at = 0;
      issue(8'hF3, 8'hA4, 1'b1, 1'b0, 32'h2);
      `CHK("npass", 2, npass)
      `CHK("susp", 1'b0, suspended)
   endtask
   task automatic t_page_fault;
      zf_seq = 8'h00;
      fault_at = 1;
      issue(8'hF2, 8'hA7, 1'b1, 1'b1, 32'h4);
      fault_at = -1;
      `CHK("restore", 1'b1, flags_restore)
      `CHK("flags", flags_in, flags_out)
      `CHK("susp", 1'b1, suspended)
      `CHK("count", 32'h3, count_out)
   endtask
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {rst_n, start, addr_32, operand_32, int_pending} = 5'h00;
      {pass_done, pass_fault, pass_page_fault, zero_flag} = 4'h0;
      {prefix_byte, opcode_byte, zf_seq} = 24'h000000;
      {count_in, flags_in, ip_in} = 96'h0;
      {src_idx_in, dst_idx_in, src_idx_next, dst_idx_next} = 128'h0;
      {failures, cmp_count, npass, lat, int_at} = 160'h0;
      fault_at = -1;
      repeat (16) @(posedge ref_clk);
      #2;
      rst_n = 1'b1;
      t_zero_entry();
      t_plain_ops();
      t_equal();
      t_unequal();
      t_count16();
      t_interrupt();
      t_page_fault();
      complete_run();
   end
   initial begin
      #200000;
      failures++;
      complete_run();
   end
endmodule
bind string_repeat_prefix_control string_repeat_prefix_control_chk #(
   .CNT_W(CNT_W)
) u_chk (
   .ref_clk, .rst_n, .start, .addr_32, .count_in, .flags_in, .int_pending,
   .int_take, .pass_req, .pass_done, .busy, .done, .suspended,
   .flags_restore, .flags_out, .count_out);
`default_nettype wire
